// ==== src/bcp_pin_ctl.sv ====
// port 6 alternate functions, dedicated strobes, trap input and reset output
`timescale 1ns/1ps
`include "bcp_defs.svh"
module bcp_pin_ctl
	import bcp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic [1:0] PORT0_CHIP_SELECT_COUNT_FIELD_I,
	output logic [1:0] CHIP_SELECT_COUNT_FIELD_O,
	input wire logic [3:0] CS_ACTIVE_N_I,
	input wire logic [7:0] P6_DATA_I,
	input wire logic [7:0] P6_DIR_I,
	input wire logic [7:0] OPEN_DRAIN_SELECT_I,
	input wire logic [7:0] P6_PIN_I,
	output logic [7:0] P6_OUT_O,
	output logic [7:0] P6_OE_O,
	output logic [7:0] P6_PULLUP_O,
	output logic [7:0] P6_IN_O,
	input wire logic ARBITRATION_PINS_ENABLE_I,
	input wire logic HOLD_MODE_I,
	input wire logic HOLD_ACK_I,
	input wire logic BUS_REQUEST_I,
	output logic HOLD_REQUEST_O,
	input wire logic BUS_CYCLE_START_I,
	input wire bcp_acc_t ACCESS_TYPE_I,
	input wire logic [4:0] BUS_WINDOW_ACTIVE_I,
	input wire logic INTERNAL_ACCESS_VISIBILITY_I,
	input wire logic RD_REQ_I,
	input wire logic WR_REQ_I,
	input wire logic WR_HIGH_REQ_I,
	input wire logic WR_LOW_REQ_I,
	input wire logic BYTE_WRITE_MODE_I,
	input wire logic READY_ENABLE_I,
	input wire logic READY_ASYNC_I,
	input wire logic [3:0] WAITSTATES_I,
	input wire logic READY_N_I,
	output logic CYCLE_END_O,
	output logic ALE_O,
	output logic READ_STROBE_N_O,
	output logic READ_STROBE_OE_O,
	output logic WRITE_LOW_STROBE_N_O,
	output logic WRITE_LOW_STROBE_OE_O,
	output logic WRITE_HIGH_STROBE_N_O,
	output logic STROBE_PULLUP_O,
	input wire logic NMI_N_I,
	output logic NMI_TRAP_O,
	output logic POWER_DOWN_VALID_O,
	input wire logic POWER_DOWN_INSTRUCTION_I,
	input wire logic WATCHDOG_OVERFLOW_I,
	input wire logic SOFTWARE_RESET_INSTRUCTION_I,
	input wire logic END_OF_INIT_INSTRUCTION_I,
	output logic RESET_OUTPUT_PIN_N_O
);
	logic [1:0] chip_select_count_field_reg;
	logic hold_d_reg;
	logic [1:0] hold_drv_cnt_reg;
	logic [1:0] hold_drv_cnt_next;
	logic reset_output_pin_n_reg;
	logic reset_output_pin_n_next;
	logic nmi_d_reg;
	logic nmi_trap_reg;
	logic pd_valid_reg;
	logic pd_valid_next;
	logic ale_reg;
	logic rd_n_reg;
	logic wrl_n_reg;
	logic wrh_n_reg;
	logic ready_meta;
	logic nmi_sync;
	logic [7:0] p6_sync;
	logic [7:0] pin_sync_vec;
	wire logic [3:0] cs_used;
	wire logic hold_drive_high;
	wire logic in_hold;
	wire logic any_window;
	wire logic ale_next;
	wire logic strobes_allowed;
	wire logic nmi_edge;

	// count is a strap, so it is caught at the clock while reset is held
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			chip_select_count_field_reg <= PORT0_CHIP_SELECT_COUNT_FIELD_I;
		end
	end
	assign CHIP_SELECT_COUNT_FIELD_O = chip_select_count_field_reg;

	// chip select 0 is present for every count setting
	assign cs_used[0] = 1'b1;
	assign cs_used[1] = (chip_select_count_field_reg != `BCP_CHIP_SELECT_COUNT_FIELD_GPIO);
	assign cs_used[2] = (chip_select_count_field_reg == `BCP_CHIP_SELECT_COUNT_FIELD_NONE) || (chip_select_count_field_reg == `BCP_CHIP_SELECT_COUNT_FIELD_THREE);
	assign cs_used[3] = (chip_select_count_field_reg == `BCP_CHIP_SELECT_COUNT_FIELD_THREE);

	assign in_hold = HOLD_MODE_I && !RESET_I;
	// the entry cycle itself drives high, the counter only stretches it
	assign hold_drive_high = (in_hold && !hold_d_reg) || (hold_drv_cnt_reg != 2'h0);
	always_comb begin
		hold_drv_cnt_next = hold_drv_cnt_reg;
		if (in_hold && !hold_d_reg) begin
			hold_drv_cnt_next = 2'(`BCP_HOLD_DRIVE_CYC - 1);
		end else if (hold_drv_cnt_reg != 2'h0) begin
			hold_drv_cnt_next = hold_drv_cnt_reg - 2'h1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_p6
			if (gi < `BCP_NUM_CS) begin : g_cs
				// chip select open drain (cs0 to cs3) takes effect only out of reset, after software writes it
				wire logic od = OPEN_DRAIN_SELECT_I[gi] && !RESET_I;
				wire logic cs_drv = cs_used[gi] && !RESET_I;
				wire logic cs_val = hold_drive_high ? 1'b1 : CS_ACTIVE_N_I[gi];
				wire logic gp_val = P6_DATA_I[gi];
				wire logic val = cs_drv ? cs_val : gp_val;
				wire logic en = cs_drv ? (!in_hold || hold_drive_high) : P6_DIR_I[gi];
				// hold entry pushes high even on an open-drain line
				wire logic push_hi = cs_drv && hold_drive_high;
				// open drain: only a low is driven, except for the high push at hold entry
				assign P6_OUT_O[gi] = (od && !push_hi) ? 1'b0 : val;
				assign P6_OE_O[gi] = !RESET_I && en && (!od || !val || push_hi);
				assign P6_PULLUP_O[gi] = RESET_I || (cs_used[gi] && in_hold && !od);
			end else if (gi == `BCP_HOLD_PIN) begin : g_hold
				wire logic gp = !ARBITRATION_PINS_ENABLE_I;
				wire logic od = OPEN_DRAIN_SELECT_I[gi];
				assign P6_OUT_O[gi] = od ? 1'b0 : P6_DATA_I[gi];
				// hold request driver switched off when arbitration is on
				assign P6_OE_O[gi] = !RESET_I && gp && P6_DIR_I[gi] && (!od || !P6_DATA_I[gi]);
				assign P6_PULLUP_O[gi] = 1'b0;
			end else begin : g_arb
				wire logic arb = ARBITRATION_PINS_ENABLE_I;
				wire logic fn = (gi == `BCP_HOLD_ACK_OUT_PIN) ? HOLD_ACK_I : BUS_REQUEST_I;
				wire logic val = arb ? !fn : P6_DATA_I[gi];
				wire logic od = OPEN_DRAIN_SELECT_I[gi];
				assign P6_OUT_O[gi] = od ? 1'b0 : val;
				assign P6_OE_O[gi] = !RESET_I && (arb || P6_DIR_I[gi]) && (!od || !val);
				assign P6_PULLUP_O[gi] = 1'b0;
			end
		end
	endgenerate

	generate
		for (gi = 0; gi < 8; gi++) begin : g_sync
			bcp_sync3 u_sync (
				.CLK_I(CLK_I),
				.RESET_I(RESET_I),
				.RST_VAL_I(1'b1),
				.D_I(P6_PIN_I[gi]),
				.Q_O(pin_sync_vec[gi])
			);
		end
	endgenerate
	assign p6_sync = pin_sync_vec;
	assign P6_IN_O = p6_sync;
	// hold request is active low on the pin
	assign HOLD_REQUEST_O = ARBITRATION_PINS_ENABLE_I && !p6_sync[`BCP_HOLD_PIN];

	assign any_window = |BUS_WINDOW_ACTIVE_I;
	assign ale_next = BUS_CYCLE_START_I && ((ACCESS_TYPE_I == BCP_ACC_EXTERNAL)
		|| ((ACCESS_TYPE_I == BCP_ACC_XPER) && any_window));
	assign strobes_allowed = (ACCESS_TYPE_I == BCP_ACC_EXTERNAL)
		|| ((ACCESS_TYPE_I == BCP_ACC_XPER) && INTERNAL_ACCESS_VISIBILITY_I);

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			ale_reg <= 1'b0;
			rd_n_reg <= 1'b1;
			wrl_n_reg <= 1'b1;
			wrh_n_reg <= 1'b1;
		end else begin
			ale_reg <= ale_next;
			rd_n_reg <= !(RD_REQ_I && strobes_allowed && !in_hold);
			// general write, or low byte only beside a high strobe
			wrl_n_reg <= !(strobes_allowed && !in_hold
				&& (BYTE_WRITE_MODE_I ? WR_LOW_REQ_I : WR_REQ_I));
			wrh_n_reg <= !(strobes_allowed && !in_hold && BYTE_WRITE_MODE_I && WR_HIGH_REQ_I);
		end
	end
	assign ALE_O = ale_reg;
	assign READ_STROBE_N_O = rd_n_reg;
	assign WRITE_LOW_STROBE_N_O = wrl_n_reg;
	assign WRITE_HIGH_STROBE_N_O = wrh_n_reg;
	// read and write-low drivers released in reset and hold so the pullups hold those strobes high
	assign READ_STROBE_OE_O = !RESET_I && !in_hold;
	assign WRITE_LOW_STROBE_OE_O = !RESET_I && !in_hold;
	assign STROBE_PULLUP_O = RESET_I || in_hold;

	bcp_sync3 u_ready_sync (
		.CLK_I(CLK_I),
		.RESET_I(RESET_I),
		.RST_VAL_I(1'b1),
		.D_I(READY_N_I),
		.Q_O(ready_meta)
	);
	bcp_ready_ctl u_ready (
		.CLK_I(CLK_I),
		.RESET_I(RESET_I),
		.cyc_start_i(BUS_CYCLE_START_I && ale_next),
		.rdy_en_i(READY_ENABLE_I),
		.waits_i(WAITSTATES_I),
		.rdy_sync_i(READY_N_I),
		.rdy_async_i(ready_meta),
		.async_sel_i(READY_ASYNC_I),
		.cyc_end_o(CYCLE_END_O)
	);

	bcp_sync3 u_nmi_sync (
		.CLK_I(CLK_I),
		.RESET_I(RESET_I),
		.RST_VAL_I(1'b1),
		.D_I(NMI_N_I),
		.Q_O(nmi_sync)
	);
	// falling edge of the active-low trap input, checked every cycle
	assign nmi_edge = nmi_d_reg && !nmi_sync;
	always_comb begin
		pd_valid_next = pd_valid_reg;
		if (nmi_edge) begin
			pd_valid_next = 1'b1;
		end else if (POWER_DOWN_INSTRUCTION_I) begin
			pd_valid_next = 1'b0;
		end
		reset_output_pin_n_next = reset_output_pin_n_reg;
		// a new reset cause wins over end-of-init in the same cycle
		if (WATCHDOG_OVERFLOW_I || SOFTWARE_RESET_INSTRUCTION_I) begin
			reset_output_pin_n_next = 1'b0;
		end else if (END_OF_INIT_INSTRUCTION_I) begin
			reset_output_pin_n_next = 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			hold_d_reg <= 1'b0;
			hold_drv_cnt_reg <= 2'h0;
			reset_output_pin_n_reg <= 1'b0;
			nmi_d_reg <= 1'b1;
			nmi_trap_reg <= 1'b0;
			pd_valid_reg <= 1'b0;
		end else begin
			hold_d_reg <= in_hold;
			hold_drv_cnt_reg <= hold_drv_cnt_next;
			reset_output_pin_n_reg <= reset_output_pin_n_next;
			nmi_d_reg <= nmi_sync;
			nmi_trap_reg <= nmi_edge;
			pd_valid_reg <= pd_valid_next;
		end
	end
	assign NMI_TRAP_O = nmi_trap_reg;
	assign POWER_DOWN_VALID_O = pd_valid_reg && POWER_DOWN_INSTRUCTION_I;
	assign RESET_OUTPUT_PIN_N_O = reset_output_pin_n_reg && !RESET_I;
endmodule

// ==== inc/bcp_defs.svh ====
// timing counts, field encodings and reset values for the bus control pin logic
`ifndef BCP_DEFS_SVH
`define BCP_DEFS_SVH
`define BCP_CLK_PERIOD_NS 100
`define BCP_HOLD_DRIVE_NS 100
`define BCP_HOLD_DRIVE_CYC ((`BCP_HOLD_DRIVE_NS + `BCP_CLK_PERIOD_NS - 1) / `BCP_CLK_PERIOD_NS)
`define BCP_CHIP_SELECT_COUNT_FIELD_NONE 2'h0
`define BCP_CHIP_SELECT_COUNT_FIELD_ONE 2'h1
`define BCP_CHIP_SELECT_COUNT_FIELD_GPIO 2'h2
`define BCP_CHIP_SELECT_COUNT_FIELD_THREE 2'h3
`define BCP_CHIP_SELECT_COUNT_FIELD_RESET 2'h0
`define BCP_P6_RESET 8'h00
`define BCP_HOLD_PIN 5
`define BCP_HOLD_ACK_OUT_PIN 6
`define BCP_BUS_REQUEST_OUT_PIN 7
`define BCP_NUM_CS 4
`endif

// ==== inc/bcp_pkg.sv ====
// types for the bus control pin logic
package bcp_pkg;
	typedef enum logic [1:0] {
		BCP_ACC_INTERNAL,
		BCP_ACC_EXTERNAL,
		BCP_ACC_XPER,
		BCP_ACC_NONE
	} bcp_acc_t;
	typedef enum {
		BCP_IDLE,
		BCP_WAIT,
		BCP_READY
	} bcp_rdy_state_t;
endpackage

// ==== src/bcp_sync3.sv ====
// three-flop synchroniser; a change counts once the second and third flops agree
`timescale 1ns/1ps
module bcp_sync3 (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic RST_VAL_I,
	input wire logic D_I,
	output logic Q_O
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic q_reg;
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			s1_reg <= RST_VAL_I;
			s2_reg <= RST_VAL_I;
			s3_reg <= RST_VAL_I;
			q_reg <= RST_VAL_I;
		end else begin
			s1_reg <= D_I;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q_reg <= s3_reg;
			end
		end
	end
	assign Q_O = q_reg;
endmodule

// ==== src/bcp_ready_ctl.sv ====
// ready evaluation for one external bus cycle, with waitstate blanking
`timescale 1ns/1ps
module bcp_ready_ctl
	import bcp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic cyc_start_i,
	input wire logic rdy_en_i,
	input wire logic [3:0] waits_i,
	input wire logic rdy_sync_i,
	input wire logic rdy_async_i,
	input wire logic async_sel_i,
	output logic cyc_end_o
);
	bcp_rdy_state_t state_reg;
	bcp_rdy_state_t state_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	wire logic rdy_seen = async_sel_i ? rdy_async_i : rdy_sync_i;
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cyc_end_o = 1'b0;
		case (state_reg)
			BCP_IDLE: begin
				if (cyc_start_i) begin
					cnt_next = waits_i;
					state_next = (waits_i != 4'h0) ? BCP_WAIT : BCP_READY;
				end
			end
			BCP_WAIT: begin
				// ready ignored while programmed waitstates run
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h1) begin
					state_next = BCP_READY;
				end
			end
			BCP_READY: begin
				// ready is active low; without ready control the cycle ends at once
				if (!rdy_en_i || !rdy_seen) begin
					cyc_end_o = 1'b1;
					state_next = BCP_IDLE;
				end
			end
			default: state_next = BCP_IDLE;
		endcase
	end
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state_reg <= BCP_IDLE;
			cnt_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule

// ==== testbench/bcp_pin_chk.sv ====
// assertions on the pins of the bus control pin logic
`timescale 1ns/1ps
module bcp_pin_chk
	import bcp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic [1:0] CHIP_SELECT_COUNT_FIELD_O,
	input wire logic [7:0] P6_DIR_I,
	input wire logic [7:0] OPEN_DRAIN_SELECT_I,
	input wire logic [7:0] P6_OUT_O,
	input wire logic [7:0] P6_OE_O,
	input wire logic [7:0] P6_PULLUP_O,
	input wire logic ARBITRATION_PINS_ENABLE_I,
	input wire logic HOLD_MODE_I,
	input wire logic HOLD_ACK_I,
	input wire logic BUS_CYCLE_START_I,
	input wire bcp_acc_t ACCESS_TYPE_I,
	input wire logic [4:0] BUS_WINDOW_ACTIVE_I,
	input wire logic ALE_O,
	input wire logic STROBE_PULLUP_O,
	input wire logic NMI_N_I,
	input wire logic NMI_TRAP_O,
	input wire logic WATCHDOG_OVERFLOW_I,
	input wire logic SOFTWARE_RESET_INSTRUCTION_I,
	input wire logic RESET_OUTPUT_PIN_N_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	logic [3:0] cs_map;
	assign cs_map = (CHIP_SELECT_COUNT_FIELD_O == 2'h2) ? 4'h1 :
		(CHIP_SELECT_COUNT_FIELD_O == 2'h1) ? 4'h3 :
		(CHIP_SELECT_COUNT_FIELD_O == 2'h0) ? 4'h7 : 4'hF;
	AST_RST_PU: assert property (disable iff (1'b0) RESET_I
		|-> P6_PULLUP_O[3:0] == 4'hF && STROBE_PULLUP_O) else $error("reset pullups off");
	AST_CS_PU: assert property (P6_PULLUP_O[3:0] ==
		(cs_map & ~OPEN_DRAIN_SELECT_I[3:0] & {4{HOLD_MODE_I}})) else $error("cs pullup");
	AST_HOLD_DRV: assert property ($rose(HOLD_MODE_I)
		|-> (P6_OE_O[3:0] & P6_OUT_O[3:0]) == cs_map ##1 (P6_OE_O[3:0] & cs_map) == 4'h0)
		else $error("hold entry drive");
	AST_ALE_SRC: assert property (ALE_O |-> $past(BUS_CYCLE_START_I) &&
		($past(ACCESS_TYPE_I) == BCP_ACC_EXTERNAL || $past(ACCESS_TYPE_I) == BCP_ACC_XPER
		&& |$past(BUS_WINDOW_ACTIVE_I))) else $error("ale without cause");
	AST_ARB: assert property (ARBITRATION_PINS_ENABLE_I
		|-> P6_OE_O[7:5] == 3'h6 && P6_OUT_O[6] == !HOLD_ACK_I) else $error("arb pins");
	AST_GPIO: assert property (!ARBITRATION_PINS_ENABLE_I && OPEN_DRAIN_SELECT_I[7:5] == 3'h0
		|-> P6_OE_O[7:5] == P6_DIR_I[7:5]) else $error("gpio direction");
	AST_RESET_OUTPUT_PIN: assert property (WATCHDOG_OVERFLOW_I || SOFTWARE_RESET_INSTRUCTION_I
		|=> !RESET_OUTPUT_PIN_N_O) else $error("reset out not low");
	AST_NMI: assert property ($fell(NMI_N_I) |-> ##[3:7] NMI_TRAP_O)
		else $error("no trap");
	AST_CHIP_SELECT_COUNT_FIELD: assert property ($stable(CHIP_SELECT_COUNT_FIELD_O))
		else $error("count field changed");
endmodule
bind bcp_pin_ctl bcp_pin_chk chk (.*);

// ==== testbench/bcp_ext_model.sv ====
// far side: pin levels, other master and ready answer
`timescale 1ns/1ps
module bcp_ext_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic end_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] out_i,
	input wire logic [7:0] pu_i,
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_val_i,
	input wire logic [3:0] rdy_dly_i,
	output logic [7:0] pin_o,
	output logic ready_n_o
);
	logic [7:0] last_reg = 8'h00;
	logic [3:0] cnt_reg = 4'h0;
	logic rdy_reg = 1'b0;
	// floating lines toggle so a stale level never passes for a drive
	assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
		| (~oe_i & ~ext_en_i & (pu_i | ~last_reg));
	assign ready_n_o = ~rdy_reg;
	always_ff @(posedge clk_i) begin
		last_reg <= pin_o;
		if (start_i) begin
			cnt_reg <= rdy_dly_i;
			rdy_reg <= 1'b0;
		end else if (end_i) begin
			// ready withdrawn once the cycle has ended
			rdy_reg <= 1'b0;
		end else if (cnt_reg > 4'h1) begin
			cnt_reg <= cnt_reg - 4'h1;
		end else if (cnt_reg == 4'h1) begin
			cnt_reg <= 4'h0;
			rdy_reg <= 1'b1;
		end
	end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the bus control pin logic
`timescale 1ns/1ps
module tb;
	import bcp_pkg::*;
	localparam int NEV = 40;
	logic CLK_I, RESET_I, ARBITRATION_PINS_ENABLE_I, HOLD_MODE_I, HOLD_ACK_I, BUS_REQUEST_I;
	logic BUS_CYCLE_START_I, INTERNAL_ACCESS_VISIBILITY_I, RD_REQ_I, WR_REQ_I, WR_HIGH_REQ_I;
	logic WR_LOW_REQ_I, BYTE_WRITE_MODE_I, READY_ENABLE_I, READY_ASYNC_I, NMI_N_I, READY_N_I;
	logic POWER_DOWN_INSTRUCTION_I, WATCHDOG_OVERFLOW_I, SOFTWARE_RESET_INSTRUCTION_I;
	logic END_OF_INIT_INSTRUCTION_I, HOLD_REQUEST_O, CYCLE_END_O, ALE_O, READ_STROBE_N_O;
	logic READ_STROBE_OE_O, WRITE_LOW_STROBE_N_O, WRITE_LOW_STROBE_OE_O, WRITE_HIGH_STROBE_N_O;
	logic STROBE_PULLUP_O, NMI_TRAP_O, POWER_DOWN_VALID_O, RESET_OUTPUT_PIN_N_O;
	logic [1:0] PORT0_CHIP_SELECT_COUNT_FIELD_I, CHIP_SELECT_COUNT_FIELD_O;
	logic [3:0] CS_ACTIVE_N_I, WAITSTATES_I, rdy_dly;
	logic [4:0] BUS_WINDOW_ACTIVE_I;
	logic [7:0] P6_DATA_I, P6_DIR_I, OPEN_DRAIN_SELECT_I, P6_PIN_I, P6_OUT_O, P6_OE_O;
	logic [7:0] P6_PULLUP_O, P6_IN_O, ext_en, ext_val;
	bcp_acc_t ACCESS_TYPE_I;
	int fails = 0;
	int compares = 0;
	bcp_pin_ctl dut (.*);
	bcp_ext_model ext (.clk_i(CLK_I), .start_i(BUS_CYCLE_START_I), .end_i(CYCLE_END_O),
		.oe_i(P6_OE_O),
		.out_i(P6_OUT_O), .pu_i(P6_PULLUP_O), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.rdy_dly_i(rdy_dly), .pin_o(P6_PIN_I), .ready_n_o(READY_N_I));
	task automatic test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask
	task automatic rst(input logic [1:0] s, input logic [3:0] m);
		RESET_I = 1'b1;
		PORT0_CHIP_SELECT_COUNT_FIELD_I = s;
		cyc(10);
		chk({P6_PULLUP_O[3:0], 2'h0, RESET_OUTPUT_PIN_N_O, STROBE_PULLUP_O}, 8'hF1);
		RESET_I = 1'b0;
		cyc(1);
		chk({6'h00, CHIP_SELECT_COUNT_FIELD_O}, {6'h00, s});
		chk({P6_OE_O[3:0], P6_OUT_O[3:0]}, {m, 4'hF});
	endtask
	task automatic pls(input logic [2:0] k, input logic e);
		{WATCHDOG_OVERFLOW_I, SOFTWARE_RESET_INSTRUCTION_I, END_OF_INIT_INSTRUCTION_I} = k;
		cyc(1);
		{WATCHDOG_OVERFLOW_I, SOFTWARE_RESET_INSTRUCTION_I, END_OF_INIT_INSTRUCTION_I} = 3'h0;
		chk({7'h00, RESET_OUTPUT_PIN_N_O}, {7'h00, e});
	endtask
	task automatic hold(input logic [3:0] od);
		OPEN_DRAIN_SELECT_I = {4'h0, od};
		HOLD_MODE_I = 1'b1;
		#1;
		chk({P6_OE_O[3:0], P6_OUT_O[3:0]}, 8'hFF);
		cyc(1);
		chk({P6_OE_O[3:0], P6_PULLUP_O[3:0]}, {4'h0, ~od});
		cyc(1);
		HOLD_MODE_I = 1'b0;
		cyc(1);
		chk({4'h0, P6_PULLUP_O[3:0]}, 8'h00);
	endtask
	task automatic arb;
		int n;
		P6_DIR_I = 8'hE0;
		P6_DATA_I = 8'hAF;
		#1;
		chk({P6_OE_O[7:5], P6_OUT_O[7:5], 2'h0}, 8'hF4);
		{ARBITRATION_PINS_ENABLE_I, HOLD_ACK_I, ext_en} = {2'h3, 8'h20};
		n = 0;
		while (HOLD_REQUEST_O !== 1'b1 && n < 10) begin
			cyc(1);
			n++;
		end
		chk({P6_OE_O[7:5], P6_OUT_O[7:6], HOLD_REQUEST_O, 2'h0}, 8'hD4);
		chk({7'h00, P6_IN_O[5]}, 8'h00);
		if (n == 10) test_done();
		{ARBITRATION_PINS_ENABLE_I, HOLD_ACK_I, ext_en, P6_DIR_I} = '0;
		cyc(1);
	endtask
	task automatic bus(input bcp_acc_t t, input logic [4:0] bw, input logic [3:0] w,
		input logic [1:0] r, input logic [3:0] d, input logic a, input int lo, input int hi);
		int n;
		ACCESS_TYPE_I = t;
		{BUS_WINDOW_ACTIVE_I, WAITSTATES_I, READY_ENABLE_I, READY_ASYNC_I, rdy_dly} = {bw, w, r, d};
		BUS_CYCLE_START_I = 1'b1;
		cyc(1);
		BUS_CYCLE_START_I = 1'b0;
		chk({7'h00, ALE_O}, {7'h00, a});
		n = 0;
		while (CYCLE_END_O !== 1'b1 && n < NEV) begin
			cyc(1);
			n++;
		end
		chk(8'(n >= lo && n <= hi), 8'h01);
		// room for the ready synchroniser to settle before the next cycle
		cyc(6);
	endtask
	task automatic strb(input bcp_acc_t t, input logic [2:0] m, input logic [3:0] q,
		input logic [2:0] e);
		ACCESS_TYPE_I = t;
		{INTERNAL_ACCESS_VISIBILITY_I, BYTE_WRITE_MODE_I, HOLD_MODE_I} = m;
		{RD_REQ_I, WR_REQ_I, WR_HIGH_REQ_I, WR_LOW_REQ_I} = q;
		cyc(2);
		chk({5'h00, READ_STROBE_N_O, WRITE_LOW_STROBE_N_O, WRITE_HIGH_STROBE_N_O}, {5'h00, e});
		if (m[0]) chk({7'h00, STROBE_PULLUP_O}, 8'h01);
		if (m[0]) chk({6'h00, READ_STROBE_OE_O, WRITE_LOW_STROBE_OE_O}, 8'h00);
		{RD_REQ_I, WR_REQ_I, WR_HIGH_REQ_I, WR_LOW_REQ_I, HOLD_MODE_I} = '0;
		cyc(1);
	endtask
	task automatic nmi;
		int n;
		NMI_N_I = 1'b0;
		n = 0;
		while (NMI_TRAP_O !== 1'b1 && n < 10) begin
			cyc(1);
			n++;
		end
		chk(8'(n < 10), 8'h01);
		if (n == 10) test_done();
		cyc(1);
		chk({7'h00, NMI_TRAP_O}, 8'h00);
		POWER_DOWN_INSTRUCTION_I = 1'b1;
		#1;
		chk({7'h00, POWER_DOWN_VALID_O}, 8'h01);
		cyc(1);
		chk({7'h00, POWER_DOWN_VALID_O}, 8'h00);
		POWER_DOWN_INSTRUCTION_I = 1'b0;
		NMI_N_I = 1'b1;
	endtask
	initial begin
		CLK_I = 1'b0;
		forever #50 CLK_I = ~CLK_I;
	end
	initial begin
		{NMI_N_I, CS_ACTIVE_N_I, P6_DATA_I} = {1'b1, 4'hF, 8'h0F};
		{PORT0_CHIP_SELECT_COUNT_FIELD_I, WAITSTATES_I, rdy_dly, BUS_WINDOW_ACTIVE_I} = '0;
		{P6_DIR_I, OPEN_DRAIN_SELECT_I, ext_en, ext_val} = '0;
		{ARBITRATION_PINS_ENABLE_I, HOLD_MODE_I, HOLD_ACK_I, BUS_REQUEST_I, BUS_CYCLE_START_I} = '0;
		{INTERNAL_ACCESS_VISIBILITY_I, RD_REQ_I, WR_REQ_I, WR_HIGH_REQ_I, WR_LOW_REQ_I} = '0;
		{BYTE_WRITE_MODE_I, READY_ENABLE_I, READY_ASYNC_I, POWER_DOWN_INSTRUCTION_I} = '0;
		{WATCHDOG_OVERFLOW_I, SOFTWARE_RESET_INSTRUCTION_I, END_OF_INIT_INSTRUCTION_I} = '0;
		ACCESS_TYPE_I = BCP_ACC_NONE;
		rst(2'h2, 4'h1);
		rst(2'h1, 4'h3);
		rst(2'h0, 4'h7);
		rst(2'h3, 4'hF);
		pls(3'h1, 1'b1);
		pls(3'h4, 1'b0);
		pls(3'h1, 1'b1);
		pls(3'h2, 1'b0);
		hold(4'h0);
		hold(4'h5);
		arb();
		bus(BCP_ACC_EXTERNAL, 5'h01, 4'h0, 2'h0, 4'h0, 1'b1, 0, 0);
		bus(BCP_ACC_EXTERNAL, 5'h02, 4'h3, 2'h0, 4'h0, 1'b1, 3, 3);
		bus(BCP_ACC_XPER, 5'h10, 4'h1, 2'h0, 4'h0, 1'b1, 1, 1);
		bus(BCP_ACC_XPER, 5'h00, 4'h1, 2'h0, 4'h0, 1'b0, 0, NEV);
		bus(BCP_ACC_INTERNAL, 5'h1F, 4'h0, 2'h0, 4'h0, 1'b0, NEV, NEV);
		bus(BCP_ACC_EXTERNAL, 5'h01, 4'h4, 2'h2, 4'h1, 1'b1, 4, 12);
		bus(BCP_ACC_EXTERNAL, 5'h01, 4'h0, 2'h2, 4'h5, 1'b1, 5, 12);
		bus(BCP_ACC_EXTERNAL, 5'h01, 4'h1, 2'h3, 4'h3, 1'b1, 3, 12);
		strb(BCP_ACC_EXTERNAL, 3'h0, 4'h8, 3'h3);
		strb(BCP_ACC_EXTERNAL, 3'h0, 4'h4, 3'h5);
		strb(BCP_ACC_EXTERNAL, 3'h2, 4'h2, 3'h6);
		strb(BCP_ACC_EXTERNAL, 3'h2, 4'h1, 3'h5);
		strb(BCP_ACC_XPER, 3'h0, 4'h8, 3'h7);
		strb(BCP_ACC_XPER, 3'h4, 4'h8, 3'h3);
		strb(BCP_ACC_EXTERNAL, 3'h1, 4'hC, 3'h7);
		nmi();
		test_done();
	end
endmodule
